/* rtl/uart_mp_port.v */
// serial port with 8/9-bit framing, address filter, transmit fifo and bit-rate timers
`timescale 1ns/1ps
`include "uart_mp_map.vh"

// ****************************************************************
// transmit fifo
// ****************************************************************
module tx_word_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk, // core clock
  input wire reset_n, // async reset, active low
  input wire in_valid, // write request
  output wire in_ready, // room for a word
  input wire [WIDTH-1:0] in_data, // word to store
  output wire out_valid, // a word is waiting
  input wire out_ready, // consumer takes the word
  output wire [WIDTH-1:0] out_data // oldest word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage array
  reg [AW-1:0] wr_ptr; // next write slot
  reg [AW-1:0] rd_ptr; // next read slot
  reg [AW:0] count; // words held
  wire push; // accepted write
  wire pop; // accepted read

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage has no reset; contents are qualified by count
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      // simultaneous push and pop keep the level
      case ({push, pop})
        2'b10: count <= count + {{AW{1'b0}}, 1'b1};
        2'b01: count <= count - {{AW{1'b0}}, 1'b1};
        default: count <= count;
      endcase
    end
  end
endmodule // tx_word_fifo

module uart_mp_port #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire CORE_CLK, // 250 MHz core clock
  input wire RESET_N, // async reset, active low
  input wire [7:0] ADDR, // register address
  input wire WR_EN, // register write strobe
  input wire [7:0] WR_DATA, // register write data
  input wire RD_EN, // register read strobe
  output reg [7:0] RD_DATA, // read data, one cycle after RD_EN
  output wire TX_READY, // transmit fifo can take a byte
  input wire TIMER_TICK, // one pulse per bit-rate timer clock
  input wire TIMER_RUN, // bit-rate timers enabled
  input wire [7:0] RELOAD_BYTE, // shared timer reload value
  input wire INT_ENABLE, // port interrupt enable
  output wire INT_REQ, // interrupt request, level
  input wire RX_PIN, // serial receive line, asynchronous
  output reg TX_PIN // serial transmit line
);
  // ****************************************************************
  // receive states
  // ****************************************************************
  localparam RX_IDLE = 2'b00;
  localparam RX_START = 2'b01;
  localparam RX_DATA = 2'b10;
  localparam RX_STOP = 2'b11;

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg frame_length_select; // 0 = 8-bit, 1 = 9-bit
  reg multiproc_filter_enable; // address / stop check enable
  reg receive_enable_bit; // receiver on
  reg tx_ninth_bit; // ninth bit for next write
  reg rx_ninth_bit; // received stop or ninth bit
  reg tx_done_flag; // sticky transmit done
  reg rx_done_flag; // sticky receive done
  reg [7:0] rx_latch; // receive latch
  reg [7:0] tx_timer; // transmit bit-rate timer
  reg [7:0] rx_timer; // receive copy of the timer
  reg tx_half; // overflow divider, transmit
  reg rx_phase; // overflow divider, receive
  reg [9:0] tx_shift; // remaining frame bits
  reg [3:0] tx_left; // bits still to send
  reg tx_busy; // frame in progress
  reg rx_meta; // synchroniser stage one
  reg rx_sync; // synchroniser stage two
  reg rx_prev; // previous synchronised level
  reg [1:0] rx_state; // receive state
  reg [8:0] rx_shift; // collected data bits
  reg [3:0] rx_count; // data bits collected
  wire ctrl_wr; // control write
  wire data_wr; // data buffer write
  wire [8:0] tx_step; // transmit timer step
  wire [8:0] rx_step; // receive timer step
  wire tx_ovf; // transmit timer overflow
  wire rx_ovf; // receive timer overflow
  wire tx_bit_tick; // transmit bit boundary
  wire rx_sample; // receive bit centre
  wire start_edge; // falling edge on receive line
  wire fifo_valid; // byte waiting to send
  wire [8:0] fifo_data; // {ninth, data}
  wire fifo_pop; // transmitter takes byte
  wire [3:0] rx_need; // data bits for current mode
  wire rx_ninth_in; // ninth or stop bit seen
  wire filter_ok; // enabled filter passes
  wire rx_accept; // frame is taken
  wire tx_done_set; // hardware sets transmit done
  wire [7:0] control_value; // control read image

  // ****************************************************************
  // shared timer arithmetic
  // ****************************************************************
  // one timer clock step: {overflow, next count}
  function [8:0] timer_step;
    input [7:0] cnt;
    input [7:0] reload;
    begin
      if (cnt == 8'hFF) begin
        timer_step = {1'b1, reload};
      end else begin
        timer_step = {1'b0, cnt + 8'h01};
      end
    end
  endfunction

  assign ctrl_wr = WR_EN & (ADDR == `SERIAL_PORT_CONTROL_ADDR);
  assign data_wr = WR_EN & (ADDR == `SERIAL_DATA_BUFFER_ADDR);
  assign tx_step = timer_step(tx_timer, RELOAD_BYTE);
  assign rx_step = timer_step(rx_timer, RELOAD_BYTE);
  assign tx_ovf = TIMER_TICK & TIMER_RUN & tx_step[8];
  assign rx_ovf = TIMER_TICK & TIMER_RUN & rx_step[8];
  assign tx_bit_tick = tx_ovf & tx_half;
  assign rx_sample = rx_ovf & ~rx_phase;

  // ****************************************************************
  // bit-rate timers
  // ****************************************************************
  // both timers count up to overflow and reload from the shared value
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_timer <= `TIMER_RESET;
      rx_timer <= `TIMER_RESET;
      tx_half <= 1'b0;
      rx_phase <= 1'b0;
    end else begin
      if (TIMER_TICK & TIMER_RUN) begin
        tx_timer <= tx_step[7:0];
      end
      if (tx_ovf) begin
        tx_half <= ~tx_half;
      end
      if (start_edge) begin
        rx_timer <= RELOAD_BYTE;
        rx_phase <= 1'b0;
      end else if (TIMER_TICK & TIMER_RUN) begin
        rx_timer <= rx_step[7:0];
        if (rx_step[8]) begin
          rx_phase <= ~rx_phase;
        end
      end
    end
  end

  // ****************************************************************
  // transmit path
  // ****************************************************************
  // fifo lets software queue bytes; a full fifo refuses the write
  // write starts transmit
  tx_word_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_tx_fifo (
    .clk(CORE_CLK),
    .reset_n(RESET_N),
    .in_valid(data_wr),
    .in_ready(TX_READY),
    .in_data({tx_ninth_bit, WR_DATA}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // full start bit
  // frames start on a bit boundary so the start bit lasts a whole bit time;
  // a queued byte follows the stop bit with no idle gap
  assign fifo_pop = fifo_valid & tx_bit_tick & (~tx_busy | (tx_left == 4'h0));
  assign tx_done_set = tx_busy & tx_bit_tick & (tx_left == 4'h1);

  // frame sequencer; start bit goes out at the bit tick that pops the byte
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_shift <= 10'h3FF;
      tx_left <= 4'h0;
      tx_busy <= 1'b0;
      TX_PIN <= 1'b1;
    end else begin
      if (fifo_pop) begin
        tx_busy <= 1'b1;
        TX_PIN <= 1'b0;
        if (frame_length_select) begin
          tx_shift <= {1'b1, fifo_data[8], fifo_data[7:0]};
          tx_left <= `FRAME9_TAIL_BITS;
        end else begin
          tx_shift <= {2'b11, fifo_data[7:0]};
          tx_left <= `FRAME8_TAIL_BITS;
        end
      end else if (tx_busy & tx_bit_tick) begin
        if (tx_left == 4'h0) begin
          tx_busy <= 1'b0;
          TX_PIN <= 1'b1;
        end else begin
          // lsb first, stop bit last
          TX_PIN <= tx_shift[0];
          tx_shift <= {1'b1, tx_shift[9:1]};
          tx_left <= tx_left - 4'h1;
        end
      end
    end
  end

  // ****************************************************************
  // receive path
  // ****************************************************************
  // two-flop synchroniser; only the second stage feeds logic
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= RX_PIN;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  assign start_edge = (rx_state == RX_IDLE) & receive_enable_bit & rx_prev & ~rx_sync;
  assign rx_need = frame_length_select ? `RX_DATA9_BITS : `RX_DATA8_BITS;
  // ninth data bit in 9-bit mode, stop bit in 8-bit mode
  assign rx_ninth_in = frame_length_select ? rx_shift[8] : rx_sync;
  assign filter_ok = ~multiproc_filter_enable | rx_ninth_in;
  assign rx_accept = (rx_state == RX_STOP) & rx_sample & ~rx_done_flag & filter_ok;

  // first overflow after the reload hits the start-bit centre
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_state <= RX_IDLE;
      rx_shift <= 9'h000;
      rx_count <= 4'h0;
    end else if (!receive_enable_bit) begin
      // disabling mid-frame drops the frame
      rx_state <= RX_IDLE;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          if (start_edge) begin
            rx_state <= RX_START;
            rx_count <= 4'h0;
          end
        end
        RX_START: begin
          if (rx_sample) begin
            // a high level here is a glitch, not a start bit
            rx_state <= rx_sync ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_sample) begin
            // shift in from the top; 8-bit frames end aligned one high
            rx_shift <= {rx_sync, rx_shift[8:1]};
            rx_count <= rx_count + 4'h1;
            if (rx_count == rx_need - 4'h1) begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_sample) begin
            rx_state <= RX_IDLE;
            if (!frame_length_select) begin
              rx_shift <= {1'b0, rx_shift[8:1]};
            end
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // control register and receive latch
  // ****************************************************************
  // done flags: hardware set wins over a software clear in the same cycle
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      frame_length_select <= 1'b0;
      multiproc_filter_enable <= 1'b0;
      receive_enable_bit <= 1'b0;
      tx_ninth_bit <= 1'b0;
      rx_ninth_bit <= 1'b0;
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      rx_latch <= `SERIAL_DATA_BUFFER_RESET;
    end else begin
      if (ctrl_wr) begin
        frame_length_select <= WR_DATA[`FRAME_LENGTH_SELECT_BIT];
        multiproc_filter_enable <= WR_DATA[`MULTIPROC_FILTER_ENABLE_BIT];
        receive_enable_bit <= WR_DATA[`RECEIVE_ENABLE_BIT];
        tx_ninth_bit <= WR_DATA[`TX_NINTH_BIT];
      end
      tx_done_flag <= (ctrl_wr ? WR_DATA[`TX_DONE_FLAG_BIT] : tx_done_flag) | tx_done_set;
      rx_done_flag <= (ctrl_wr ? WR_DATA[`RX_DONE_FLAG_BIT] : rx_done_flag) | rx_accept;
      if (rx_accept) begin
        // 8-bit frames: data sits in the top eight bits before the final shift
        rx_latch <= frame_length_select ? rx_shift[7:0] : rx_shift[8:1];
        rx_ninth_bit <= rx_ninth_in;
      end else if (ctrl_wr) begin
        rx_ninth_bit <= WR_DATA[`RX_NINTH_BIT];
      end
    end
  end

  assign control_value = {frame_length_select, 1'b1, multiproc_filter_enable,
                          receive_enable_bit, tx_ninth_bit, rx_ninth_bit,
                          tx_done_flag, rx_done_flag};

  // registered read port; unmapped addresses read zero
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RD_DATA <= 8'h00;
    end else if (RD_EN) begin
      if (ADDR == `SERIAL_PORT_CONTROL_ADDR) begin
        RD_DATA <= control_value;
      end else if (ADDR == `SERIAL_DATA_BUFFER_ADDR) begin
        RD_DATA <= rx_latch;
      end else begin
        RD_DATA <= 8'h00;
      end
    end
  end

  assign INT_REQ = INT_ENABLE & (tx_done_flag | rx_done_flag);
endmodule // uart_mp_port

/* rtl/uart_mp_map.vh */
// register addresses, control field positions, reset values and frame counts
`ifndef UART_MP_MAP_VH
`define UART_MP_MAP_VH

// ****************************************************************
// register addresses
// ****************************************************************
`define SERIAL_PORT_CONTROL_ADDR 8'h98
`define SERIAL_DATA_BUFFER_ADDR 8'h99

// ****************************************************************
// serial_port_control field positions
// ****************************************************************
`define FRAME_LENGTH_SELECT_BIT 7
`define UNUSED_ONE_BIT 6
`define MULTIPROC_FILTER_ENABLE_BIT 5
`define RECEIVE_ENABLE_BIT 4
`define TX_NINTH_BIT 3
`define RX_NINTH_BIT 2
`define TX_DONE_FLAG_BIT 1
`define RX_DONE_FLAG_BIT 0

// ****************************************************************
// reset values
// ****************************************************************
`define SERIAL_PORT_CONTROL_RESET 8'h40
`define SERIAL_DATA_BUFFER_RESET 8'h00
`define TIMER_RESET 8'h00

// ****************************************************************
// frame counts (transmit: bits after the start bit, stop included; receive: data bits only)
// ****************************************************************
`define FRAME8_TAIL_BITS 4'h9
`define FRAME9_TAIL_BITS 4'hA
`define RX_DATA8_BITS 4'h8
`define RX_DATA9_BITS 4'h9

`endif

/* dv/uart_mp_port_assertions.sv */
// port-level checker for the multiprocessor serial port
`timescale 1ns/1ps
`include "uart_mp_map.vh"
module uart_mp_port_checker #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4,
  parameter BIT_CYCLES = 8
) (
  input wire CORE_CLK, // core clock
  input wire RESET_N, // async reset, active low
  input wire [7:0] ADDR, // register address
  input wire WR_EN, // write strobe
  input wire RD_EN, // read strobe
  input wire [7:0] RD_DATA, // read data
  input wire TX_READY, // fifo has room
  input wire INT_ENABLE, // interrupt enable
  input wire INT_REQ, // interrupt request
  input wire TX_PIN // serial out
);
  reg [7:0] quiet; // cycles the transmit line has stayed high
  // longer than the longest frame, so no frame and no queued byte remain
  wire idle_long = (quiet > 12 * BIT_CYCLES);
  // ****************************************************************
  // quiet-line counter, saturating
  // ****************************************************************
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      quiet <= 8'h00;
    end else if (!TX_PIN) begin
      quiet <= 8'h00;
    end else if (quiet != 8'hFF) begin
      quiet <= quiet + 8'h01;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_data_write;
    WR_EN && ADDR == `SERIAL_DATA_BUFFER_ADDR && TX_READY && idle_long;
  endsequence
  // the pop waits for the next bit boundary, at most one bit time away
  sequence s_start_bit;
    ##[2:9] !TX_PIN;
  endsequence
  sequence s_masked_pulse;
    INT_REQ && INT_ENABLE && !WR_EN ##1 !INT_ENABLE && !WR_EN ##1 INT_ENABLE;
  endsequence
  property p_write_starts; s_data_write |-> s_start_bit; endproperty
  a_write_starts: assert property (p_write_starts) else $error("data write did not start frame");
  property p_bit6_one; RD_EN && ADDR == `SERIAL_PORT_CONTROL_ADDR |=> RD_DATA[6]; endproperty
  a_bit6_one: assert property (p_bit6_one) else $error("control bit 6 read as zero");
  property p_unmapped_zero;
    RD_EN && ADDR != `SERIAL_PORT_CONTROL_ADDR && ADDR != `SERIAL_DATA_BUFFER_ADDR
      |=> RD_DATA == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_rd_holds; !RD_EN |=> $stable(RD_DATA); endproperty
  a_rd_holds: assert property (p_rd_holds) else $error("read data moved without read");
  property p_int_masked; !INT_ENABLE |-> !INT_REQ; endproperty
  a_int_masked: assert property (p_int_masked) else $error("request while disabled");
  property p_flag_holds; INT_REQ && INT_ENABLE && !WR_EN |=> INT_REQ || !INT_ENABLE; endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("done flag cleared by hardware");
  property p_mask_keeps; s_masked_pulse |-> INT_REQ; endproperty
  a_mask_keeps: assert property (p_mask_keeps) else $error("flag lost across masking");
  property p_reset_idle;
    $rose(RESET_N) |-> TX_PIN && TX_READY && !INT_REQ && RD_DATA == 8'h00;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
endmodule // uart_mp_port_checker

bind uart_mp_port uart_mp_port_checker #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW))
  i_uart_mp_port_checker (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WR_EN(WR_EN),
  .RD_EN(RD_EN), .RD_DATA(RD_DATA), .TX_READY(TX_READY), .INT_ENABLE(INT_ENABLE),
  .INT_REQ(INT_REQ), .TX_PIN(TX_PIN));

/* dv/remote_uart_model.sv */
// remote serial port facing the device's transmit and receive lines
`timescale 1ns/1ps
module remote_uart_model #(
  parameter BIT_CYCLES = 8
) (
  input wire clk, // core clock
  input wire nine_bit, // frames carry a ninth data bit
  input wire line_in, // device transmit line
  output reg line_out // device receive line
);
  reg [9:0] frames [0:63]; // received {stop, ninth or stop, data}
  reg [9:0] shift; // bits as they arrive
  integer n_rx; // frames received so far
  integer i;
  initial begin
    line_out = 1'b1;
    n_rx = 0;
  end
  // ****************************************************************
  // receiver: start edge, then centre samples
  // ****************************************************************
  // lsb first framing
  always begin
    @(negedge line_in);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (i = 0; i < (nine_bit ? 10 : 9); i = i + 1) begin
      repeat (BIT_CYCLES) @(posedge clk);
      shift = {line_in, shift[9:1]};
    end
    // 8-bit frames keep the stop level in the ninth position too
    frames[n_rx] = nine_bit ? shift : {shift[9], shift[9], shift[8:1]};
    n_rx = n_rx + 1;
  end
  // ****************************************************************
  // transmitter: whole frame at a fixed bit time
  // ****************************************************************
  // ninth bit as the caller orders
  task send_frame(input [7:0] d, input n, input s);
    reg [10:0] bits;
    integer k;
    begin
      bits = nine_bit ? {s, n, d, 1'b0} : {1'b1, s, d, 1'b0};
      for (k = 0; k < (nine_bit ? 11 : 10); k = k + 1) begin
        line_out <= bits[k];
        repeat (BIT_CYCLES) @(posedge clk);
      end
      line_out <= 1'b1;
    end
  endtask
endmodule // remote_uart_model

/* dv/uart_mp_port_tb.sv */
// self-checking bench for the multiprocessor serial port
`timescale 1ns/1ps
`include "uart_mp_map.vh"
module uart_mp_port_tb;
  localparam [7:0] CTRL = `SERIAL_PORT_CONTROL_ADDR; // control address
  localparam [7:0] DBUF = `SERIAL_DATA_BUFFER_ADDR; // data address
  localparam BIT = 8; // reload 0xFC: overflow every 4 ticks, bit is 2 overflows
  reg core_clk, reset_n, wr_en, rd_en, timer_tick, timer_run, int_enable, nine_bit;
  reg [7:0] addr, wr_data, reload_byte, got, c, d, n, s, ec, ed;
  wire [7:0] rd_data;
  wire tx_ready, int_req, rx_line, tx_pin;
  integer n_errors, checked, cycles, k, j, base, n_acc;
  reg [23:0] reg_rows [0:5]; // {addr, write, expected read}
  reg [47:0] rx_rows [0:7]; // {ctrl, data, ninth, stop, expected ctrl, expected data}
  reg [23:0] tx_rows [0:2]; // {ctrl, data, expected ninth or stop}
  uart_mp_port #(.FIFO_DEPTH(16), .FIFO_AW(4)) i_uart_mp_port (.CORE_CLK(core_clk),
    .RESET_N(reset_n), .ADDR(addr), .WR_EN(wr_en), .WR_DATA(wr_data), .RD_EN(rd_en),
    .RD_DATA(rd_data), .TX_READY(tx_ready), .TIMER_TICK(timer_tick), .TIMER_RUN(timer_run),
    .RELOAD_BYTE(reload_byte), .INT_ENABLE(int_enable), .INT_REQ(int_req), .RX_PIN(rx_line),
    .TX_PIN(tx_pin));
  remote_uart_model #(.BIT_CYCLES(BIT)) i_remote_uart_model (.clk(core_clk),
    .nine_bit(nine_bit), .line_in(tx_pin), .line_out(rx_line));
  // ****************************************************************
  // clock and watchdog
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // a hang counts as a mismatch and ends the run
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task check(input [9:0] g, input [9:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task reg_write(input [7:0] a, input [7:0] v);
    begin
      @(posedge core_clk);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge core_clk);
      wr_en <= 1'b0;
      #1;
    end
  endtask
  task reg_read(input [7:0] a, output [7:0] v);
    begin
      @(posedge core_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1;
      v = rd_data;
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {reset_n, wr_en, rd_en, nine_bit} = 4'h0;
    {timer_tick, timer_run, int_enable} = 3'h7; // timer ticks every core cycle
    {addr, wr_data, reload_byte} = {16'h0000, 8'hFC};
    {n_errors, checked, cycles} = 0;
    reg_rows[0] = 24'h98_00_40; reg_rows[1] = 24'h98_B8_F8; reg_rows[2] = 24'h98_FF_FF;
    reg_rows[3] = 24'h98_3F_7F; reg_rows[4] = 24'h98_00_40; reg_rows[5] = 24'h50_A5_00;
    rx_rows[0] = 48'h10_3C_00_01_55_3C; rx_rows[1] = 48'h11_77_00_01_51_3C;
    rx_rows[2] = 48'h30_11_00_00_70_3C; rx_rows[3] = 48'h10_11_00_00_51_11;
    rx_rows[4] = 48'h00_99_00_01_40_11; rx_rows[5] = 48'hB0_5A_00_01_F0_11;
    rx_rows[6] = 48'hB0_81_01_01_F5_81; rx_rows[7] = 48'h90_42_00_00_D1_42;
    tx_rows[0] = 24'h10_A5_01; tx_rows[1] = 24'h98_C3_01; tx_rows[2] = 24'h90_3C_00;
    repeat (20) @(posedge core_clk);
    check({6'h00, tx_pin, tx_ready, int_req, 1'b0}, 10'h00C); // idle during reset
    check({2'b00, rd_data}, 10'h000);
    reset_n <= 1'b1;
    reg_read(CTRL, got);
    check({2'b00, got}, 10'h040);
    reg_read(DBUF, got);
    check({2'b00, got}, 10'h000);
    $display("test reset done");
    // register rows: write then read back
    for (k = 0; k < 6; k = k + 1) begin
      reg_write(reg_rows[k][23:16], reg_rows[k][15:8]);
      reg_read(reg_rows[k][23:16], got);
      check({2'b00, got}, {2'b00, reg_rows[k][7:0]});
    end
    $display("test registers done");
    // receive rows: mode, filter, enable and overrun cases
    for (k = 0; k < 8; k = k + 1) begin
      {c, d, n, s, ec, ed} = rx_rows[k];
      nine_bit <= c[7];
      reg_write(CTRL, c);
      i_remote_uart_model.send_frame(d, n[0], s[0]);
      repeat (3 * BIT) @(posedge core_clk);
      reg_read(CTRL, got);
      check({2'b00, got}, {2'b00, ec});
      reg_read(DBUF, got);
      check({2'b00, got}, {2'b00, ed});
    end
    $display("test receive done");
    // transmit rows: ninth bit, done timing, flag persistence
    for (k = 0; k < 3; k = k + 1) begin
      nine_bit <= tx_rows[k][23];
      reg_write(CTRL, tx_rows[k][23:16]);
      base = i_remote_uart_model.n_rx;
      reg_write(DBUF, tx_rows[k][15:8]);
      for (j = 0; j < 200 && int_req !== 1'b1; j = j + 1) begin @(posedge core_clk); #1; end
      check({tx_pin, int_req, 8'h00}, 10'h300);
      check(i_remote_uart_model.n_rx - base, 10'h000); // set before stop centre
      for (j = 0; j < 200 && i_remote_uart_model.n_rx == base; j = j + 1) @(posedge core_clk);
      check(i_remote_uart_model.frames[base], {1'b1, tx_rows[k][0], tx_rows[k][15:8]});
      @(posedge core_clk) int_enable <= 1'b0;
      @(posedge core_clk) int_enable <= 1'b1;
      repeat (3) @(posedge core_clk);
      check({9'h000, int_req}, 10'h001);
      reg_write(CTRL, tx_rows[k][23:16]);
      check({9'h000, int_req}, 10'h000); // software clear
    end
    $display("test transmit done");
    // fill the fifo until it refuses, then one dropped write, then drain
    nine_bit <= 1'b0;
    reg_write(CTRL, 8'h10);
    base = i_remote_uart_model.n_rx;
    n_acc = 0;
    while (tx_ready === 1'b1 && n_acc < 40) begin
      reg_write(DBUF, 8'h20 + n_acc[7:0]);
      n_acc = n_acc + 1;
    end
    check(n_acc, 10'h011); // sixteen queued plus one shifting
    reg_write(DBUF, 8'hEE);
    for (j = 0; j < 2000 && i_remote_uart_model.n_rx < base + n_acc; j = j + 1) begin
      @(posedge core_clk);
    end
    repeat (25 * BIT) @(posedge core_clk);
    check(i_remote_uart_model.n_rx - base, n_acc); // refused byte never sent
    for (j = 0; j < n_acc; j = j + 1) begin
      check(i_remote_uart_model.frames[base + j], {2'b11, 8'h20 + j[7:0]});
    end
    $display("test fifo done");
    // reference reloads: one bit is 2 * (256 - reload) timer clocks
    for (k = 0; k < 2; k = k + 1) begin
      reg_write(CTRL, 8'h10);
      reg_write(DBUF, 8'h55);
      // switch the reload only once the start bit is out
      @(negedge tx_pin);
      @(posedge core_clk) reload_byte <= k ? 8'h93 : 8'h96;
      @(posedge tx_pin);
      for (j = 0; j < 600 && tx_pin === 1'b1; j = j + 1) begin
        @(posedge core_clk);
        #1;
      end
      check(j, k ? 10'h0DA : 10'h0D4);
      for (j = 0; j < 3000 && int_req !== 1'b1; j = j + 1) @(posedge core_clk);
    end
    $display("test bit rate done");
    tally_and_finish;
  end
endmodule // uart_mp_port_tb
